// file: logic/fileop_pkg.sv
// package: opcodes, field layout and widths of the file-register unary unit
package fileop_pkg;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int PC_W       = 13;
  localparam int LIT_W      = 11;
  localparam int OPC_W      = 3;
  localparam int PAGE_LO    = 3;
  localparam int PAGE_HI    = 4;
  localparam int JUMP_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  localparam logic [7:0]  ONE_BYTE  = 8'h01;
  localparam logic [12:0] PC_RESET  = 13'h0000;
  localparam logic [7:0]  W_RESET   = 8'h00;
  typedef enum logic [2:0] {
    no_operation           = 3'h0,
    complement_file_op     = 3'h1,
    decrement_file_op      = 3'h2,
    increment_file_op      = 3'h3,
    decrement_skip_zero_op = 3'h4,
    increment_skip_zero_op = 3'h5,
    jump_absolute_op       = 3'h6
  } op_t;
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } state_t;
endpackage : fileop_pkg

// file: logic/unary_alu.sv
// combinational unary datapath: complement, decrement, increment
`timescale 1ns/1ps
`default_nettype none
module unary_alu (
  // operation and operand
  input  wire fileop_pkg::op_t                    op,
  input  wire logic [fileop_pkg::DATA_W-1:0]      operand,
  // result
  output logic      [fileop_pkg::DATA_W-1:0]      result,
  output logic                                    is_zero
);
  always_comb begin
    unique case (op)
      fileop_pkg::complement_file_op:     result = ~operand;
      fileop_pkg::decrement_file_op,
      fileop_pkg::decrement_skip_zero_op: result = operand - fileop_pkg::ONE_BYTE;
      fileop_pkg::increment_file_op,
      fileop_pkg::increment_skip_zero_op: result = operand + fileop_pkg::ONE_BYTE;
      default:                            result = operand;
    endcase
    is_zero = (result == fileop_pkg::ZERO_BYTE);
  end
endmodule : unary_alu
`default_nettype wire

// file: logic/file_unary_core.sv
// execution unit for file-register unary ops, skips and absolute jump
`timescale 1ns/1ps
`default_nettype none
module file_unary_core (
  // clock and control
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  input  wire logic                                 ce,
  // instruction issue
  input  wire logic                                 issue_valid,
  input  wire fileop_pkg::op_t                      issue_op,
  input  wire logic                                 dest_file,
  input  wire logic [fileop_pkg::FADDR_W-1:0]       file_addr,
  input  wire logic [fileop_pkg::LIT_W-1:0]         jump_literal,
  // operands from the core
  input  wire logic [fileop_pkg::DATA_W-1:0]        file_rdata,
  input  wire logic [fileop_pkg::DATA_W-1:0]        program_page_latch,
  // results
  output logic                                      ready,
  output logic      [fileop_pkg::DATA_W-1:0]        work_reg,
  output logic                                      zero_flag,
  output logic                                      file_we,
  output logic      [fileop_pkg::FADDR_W-1:0]       file_waddr,
  output logic      [fileop_pkg::DATA_W-1:0]        file_wdata,
  output logic      [fileop_pkg::PC_W-1:0]          pc,
  output logic                                      flush
);
  // control group
  fileop_pkg::state_t                 state_r, state_nxt;
  logic                               rdy_r, rdy_nxt;
  logic                               fl_r, fl_nxt;
  // working register and flag groups
  logic [fileop_pkg::DATA_W-1:0]      w_r, w_nxt;
  logic                               z_r, z_nxt;
  // file write group
  logic                               we_r, we_nxt;
  logic [fileop_pkg::FADDR_W-1:0]     wa_r, wa_nxt;
  logic [fileop_pkg::DATA_W-1:0]      fwd_r, fwd_nxt;
  // program counter group
  logic [fileop_pkg::PC_W-1:0]        pc_r, pc_nxt;
  logic [fileop_pkg::PC_W-1:0]        jump_target;
  // datapath and decode
  logic [fileop_pkg::DATA_W-1:0]      alu_res;
  logic                               alu_zero;
  logic                               take;
  logic                               is_unary;
  logic                               is_skip;
  logic                               is_jump;
  logic                               sets_zero;
  logic                               skip_hit;
  logic                               redirect;

  // shared datapath; its result is used only when a unary op is taken
  unary_alu u_alu (
    .op      (issue_op),
    .operand (file_rdata),
    .result  (alu_res),
    .is_zero (alu_zero)
  );

  // an issue only counts in an execute cycle; ce gates the registers
  assign take = issue_valid && (state_r == fileop_pkg::ST_EXEC);

  // decode of the taken instruction
  always_comb begin
    is_unary  = 1'b0;
    is_skip   = 1'b0;
    is_jump   = 1'b0;
    sets_zero = 1'b0;
    unique case (issue_op)
      fileop_pkg::no_operation: begin
        is_jump = 1'b0;
      end
      fileop_pkg::complement_file_op,
      fileop_pkg::decrement_file_op,
      fileop_pkg::increment_file_op: begin
        is_unary  = take;
        sets_zero = take;
      end
      fileop_pkg::decrement_skip_zero_op,
      fileop_pkg::increment_skip_zero_op: begin
        is_unary = take;
        is_skip  = take;
      end
      fileop_pkg::jump_absolute_op: begin
        is_jump = take;
      end
      default: ;
    endcase
  end

  // a zero result from a skip op drops the instruction already fetched
  assign skip_hit    = is_skip && alu_zero;
  assign redirect    = is_jump || skip_hit;
  assign jump_target = {program_page_latch[fileop_pkg::PAGE_HI:fileop_pkg::PAGE_LO],
                        jump_literal};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fileop_pkg::ST_EXEC: begin
        if (redirect) begin
          state_nxt = fileop_pkg::ST_FLUSH;
        end
      end
      fileop_pkg::ST_FLUSH: begin
        state_nxt = fileop_pkg::ST_EXEC;
      end
      default: begin
        state_nxt = fileop_pkg::ST_EXEC;
      end
    endcase
    // ready is registered, so it already shows the coming cycle
    rdy_nxt = (state_nxt == fileop_pkg::ST_EXEC);
    fl_nxt  = redirect;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= fileop_pkg::ST_EXEC;
      rdy_r   <= 1'b1;
      fl_r    <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      rdy_r   <= rdy_nxt;
      fl_r    <= fl_nxt;
    end
  end

  // working register
  always_comb begin
    w_nxt = w_r;
    if (is_unary && !dest_file) begin
      w_nxt = alu_res;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_r <= fileop_pkg::W_RESET;
    end else if (ce) begin
      w_r <= w_nxt;
    end
  end

  // zero flag; skip ops and jump leave it alone
  always_comb begin
    z_nxt = z_r;
    if (sets_zero) begin
      z_nxt = alu_zero;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      z_r <= 1'b0;
    end else if (ce) begin
      z_r <= z_nxt;
    end
  end

  // file write port: one-cycle strobe, address and data hold after it
  always_comb begin
    we_nxt  = 1'b0;
    wa_nxt  = wa_r;
    fwd_nxt = fwd_r;
    if (is_unary && dest_file) begin
      we_nxt  = 1'b1;
      wa_nxt  = file_addr;
      fwd_nxt = alu_res;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      we_r  <= 1'b0;
      wa_r  <= '0;
      fwd_r <= fileop_pkg::ZERO_BYTE;
    end else if (ce) begin
      we_r  <= we_nxt;
      wa_r  <= wa_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  // program counter: jump target, skip over one word, or next word
  always_comb begin
    pc_nxt = pc_r;
    if (is_jump) begin
      pc_nxt = jump_target;
    end else if (skip_hit) begin
      pc_nxt = pc_r + 13'h0002;
    end else if (take) begin
      pc_nxt = pc_r + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_r <= fileop_pkg::PC_RESET;
    end else if (ce) begin
      pc_r <= pc_nxt;
    end
  end

  assign ready      = rdy_r;
  assign work_reg   = w_r;
  assign zero_flag  = z_r;
  assign file_we    = we_r;
  assign file_waddr = wa_r;
  assign file_wdata = fwd_r;
  assign pc         = pc_r;
  assign flush      = fl_r;
endmodule : file_unary_core
`default_nettype wire

// file: bench/file_unary_core_asserts.sv
// checker: result and timing relations of the unary unit
`timescale 1ns/1ps
`default_nettype none
module file_unary_core_asserts (
  // clock and control
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            ce,
  // instruction issue
  input wire logic            issue_valid,
  input wire fileop_pkg::op_t issue_op,
  input wire logic            dest_file,
  input wire logic [6:0]      file_addr,
  input wire logic [10:0]     jump_literal,
  // operands
  input wire logic [7:0]      file_rdata,
  input wire logic [7:0]      program_page_latch,
  // results
  input wire logic            ready,
  input wire logic [7:0]      work_reg,
  input wire logic            zero_flag,
  input wire logic            file_we,
  input wire logic [6:0]      file_waddr,
  input wire logic [7:0]      file_wdata,
  input wire logic [12:0]     pc,
  input wire logic            flush
);
  wire tk = ce && issue_valid && ready;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hold; flush && !ready ##1 ready; endsequence
  a_jump_pc: assert property (tk && issue_op == fileop_pkg::jump_absolute_op |=>
    pc == {$past(program_page_latch[4:3]), $past(jump_literal)}) else $error("jump pc");
  a_jump_stall: assert property (tk && issue_op == fileop_pkg::jump_absolute_op
    |=> s_hold) else $error("jump cycles");
  a_dskip_zero: assert property (tk && issue_op == fileop_pkg::decrement_skip_zero_op
    && file_rdata == 8'h01 |=> s_hold) else $error("dec skip");
  a_iskip_zero: assert property (tk && issue_op == fileop_pkg::increment_skip_zero_op
    && file_rdata == 8'hFF |=> s_hold) else $error("inc skip");
  a_iskip_none: assert property (tk && issue_op == fileop_pkg::increment_skip_zero_op
    && file_rdata != 8'hFF |=> ready && !flush) else $error("false skip");
  a_skip_flags: assert property (tk && issue_op >= fileop_pkg::decrement_skip_zero_op
    |=> $stable(zero_flag)) else $error("flag moved");
  a_comp_work: assert property (tk && issue_op == fileop_pkg::complement_file_op && !dest_file
    |=> work_reg == ~$past(file_rdata)) else $error("complement");
  a_dec_write: assert property (tk && issue_op == fileop_pkg::decrement_file_op && dest_file
    |=> file_we && file_wdata == $past(file_rdata) - 8'h01 && file_waddr == $past(file_addr))
    else $error("dec write");
  a_inc_zero: assert property (tk && issue_op == fileop_pkg::increment_file_op
    |=> zero_flag == ($past(file_rdata) == 8'hFF)) else $error("inc zero");
endmodule : file_unary_core_asserts
bind file_unary_core file_unary_core_asserts i_chk (
  .clk                (clk),
  .rst                (rst),
  .ce                 (ce),
  .issue_valid        (issue_valid),
  .issue_op           (issue_op),
  .dest_file          (dest_file),
  .file_addr          (file_addr),
  .jump_literal       (jump_literal),
  .file_rdata         (file_rdata),
  .program_page_latch (program_page_latch),
  .ready              (ready),
  .work_reg           (work_reg),
  .zero_flag          (zero_flag),
  .file_we            (file_we),
  .file_waddr         (file_waddr),
  .file_wdata         (file_wdata),
  .pc                 (pc),
  .flush              (flush)
);
`default_nettype wire

// file: bench/tb_top.sv
// bench: directed scenarios for the unary unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic            clk = 1'h0, rst = 1'h1, ce = 1'h1, issue_valid = 1'h0, dest_file = 1'h0;
  fileop_pkg::op_t issue_op = fileop_pkg::no_operation;
  logic [6:0]      file_addr = 7'h00, file_waddr;
  logic [10:0]     jump_literal = 11'h000;
  logic [7:0]      file_rdata = 8'h00, program_page_latch = 8'h00, work_reg, file_wdata;
  logic            ready, zero_flag, file_we, flush;
  logic [12:0]     pc, ep = 13'h0000;
  int              bad_count = 0, tests_run = 0;
  always #2 clk = ~clk;
  file_unary_core i_file_unary_core (
    .clk                (clk),
    .rst                (rst),
    .ce                 (ce),
    .issue_valid        (issue_valid),
    .issue_op           (issue_op),
    .dest_file          (dest_file),
    .file_addr          (file_addr),
    .jump_literal       (jump_literal),
    .file_rdata         (file_rdata),
    .program_page_latch (program_page_latch),
    .ready              (ready),
    .work_reg           (work_reg),
    .zero_flag          (zero_flag),
    .file_we            (file_we),
    .file_waddr         (file_waddr),
    .file_wdata         (file_wdata),
    .pc                 (pc),
    .flush              (flush)
  );
  task chk(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task iss(input fileop_pkg::op_t op, input logic d, input logic [7:0] rd, input logic [12:0] s);
    @(posedge clk);
    issue_valid <= 1'h1;
    issue_op <= op;
    dest_file <= d;
    file_rdata <= rd;
    file_addr <= rd[6:0];
    @(posedge clk);
    issue_valid <= 1'h0;
    #1;
    ep = ep + s;
    chk(pc, ep);
  endtask : iss
  task t_unary;
    iss(fileop_pkg::complement_file_op, 1'h0, 8'hA5, 13'h0001);
    chk(work_reg, 8'h5A);
    iss(fileop_pkg::complement_file_op, 1'h1, 8'hFF, 13'h0001);
    chk(file_wdata, 8'h00);
    chk(zero_flag, 1'h1);
    iss(fileop_pkg::decrement_file_op, 1'h0, 8'h00, 13'h0001);
    chk(work_reg, 8'hFF);
    chk(file_we, 1'h0);
    iss(fileop_pkg::decrement_file_op, 1'h1, 8'h05, 13'h0001);
    chk(file_we, 1'h1);
    chk(file_wdata, 8'h04);
    chk(file_waddr, 7'h05);
    chk(zero_flag, 1'h0);
    iss(fileop_pkg::increment_file_op, 1'h1, 8'hFF, 13'h0001);
    chk(file_waddr, 7'h7F);
    chk(zero_flag, 1'h1);
  endtask : t_unary
  task t_skip;
    iss(fileop_pkg::decrement_skip_zero_op, 1'h0, 8'h01, 13'h0002);
    chk(work_reg, 8'h00);
    chk(flush, 1'h1);
    iss(fileop_pkg::increment_skip_zero_op, 1'h1, 8'hFF, 13'h0002);
    chk(file_wdata, 8'h00);
    iss(fileop_pkg::increment_skip_zero_op, 1'h0, 8'h10, 13'h0001);
    chk(work_reg, 8'h11);
    chk(zero_flag, 1'h1);
  endtask : t_skip
  task t_hold;
    @(posedge clk);
    ce <= 1'h0;
    issue_valid <= 1'h1;
    issue_op <= fileop_pkg::increment_file_op;
    dest_file <= 1'h0;
    file_rdata <= 8'h20;
    repeat (2) @(posedge clk);
    #1;
    chk(pc, ep);
    chk(work_reg, 8'h11);
    @(posedge clk);
    ce <= 1'h1;
    @(posedge clk);
    issue_valid <= 1'h0;
    #1;
    ep = ep + 13'h0001;
    chk(pc, ep);
    chk(work_reg, 8'h21);
  endtask : t_hold
  task t_jump;
    @(posedge clk);
    program_page_latch <= 8'hF7;
    jump_literal <= 11'h555;
    ep = 13'h1555;
    iss(fileop_pkg::jump_absolute_op, 1'h0, 8'h00, 13'h0000);
    chk(ready, 1'h0);
    @(posedge clk);
    #1;
    chk(ready, 1'h1);
  endtask : t_jump
  task results;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_unary;
    t_skip;
    t_hold;
    t_jump;
    results;
  end
  initial begin
    #2000;
    bad_count++;
    results;
  end
endmodule : tb_top
`default_nettype wire
